// [core/sac_pkg.sv]
// shared constants and types for the conversion control and readout block
package sac_pkg;
    localparam int CHANNELS = 8;
    localparam int HALF = 4;
    localparam int RES_W = 16;
    localparam int BYTE_W = 8;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS = 4000;
    localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CNT_W = 13;
    localparam logic [CONV_CNT_W-1:0] CONV_CYC_V = CONV_CNT_W'(CONV_CYC);
    localparam logic [CONV_CNT_W-1:0] CONV_LAST = 13'h0001;
    localparam logic [2:0] OS_SEL_MAX = 3'h6;
    localparam int FALL_W = 7;
    localparam logic [FALL_W-1:0] FALL_MAX = 7'h7F;
    localparam logic [FALL_W-1:0] FALL_FIRST = 7'h01;
    localparam logic [FALL_W-1:0] SER_FLAG_FALLS = 7'h10;
    localparam int BIT_W = 6;
    localparam int DB_BYTE_SEL_BIT = 15;
    localparam int DB_HIGH_BYTE_FIRST_ENABLE_BIT = 14;
    localparam int SER_LOWER_BIT = 7;
    localparam int SER_UPPER_BIT = 8;
    localparam logic [RES_W-1:0] RES_ZERO = 16'h0000;
    typedef enum logic [2:0] {
        SAC_IDLE = 3'b001,
        SAC_ARMED = 3'b010,
        SAC_CONV = 3'b100
    } sac_conv_e;
endpackage

// [core/sac_sync2.sv]
// two flip-flop level synchroniser for pin inputs
`timescale 1ns/1ps
module sac_sync2 #(
    parameter int W = 1
) (
    input wire logic clk, // destination clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [W-1:0] d, // asynchronous levels
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// [core/sac_conv_readout.sv]
// conversion control and result readout of a simultaneous sampling converter
// Overview of operation
// - range_wide high selects wide span on all channels, low the narrow span.
// - range change takes effect at once; host avoids changing it mid conversion.
// - start_group_a samples channels 1-4, start_group_b samples channels 5-8.
// - a rising start edge puts that group's track-and-hold into hold.
// - a rising edge on the reset pin resets conversion state, holds and result registers.
// - reset during a conversion abandons it.
// - reset during readout clears all result registers to zero.
// - parallel mode drives the 16-bit bus only while chip select and read are low.
// - serial mode chip select fall enables both serial outputs showing the MSB.
// - each serial clock rise shifts the next bit onto both serial outputs.
// - busy rises once both start inputs have had rising edges.
// - busy stays high until every channel is converted.
// - busy falling latches new results into the output registers.
// - start edges are ignored while busy is high.
// - first channel flag floats while chip select is high, driven after its fall.
// - parallel/byte: flag set on read fall giving channel 1, cleared on next fall.
// - serial: flag set at chip select fall, cleared on the 16th clock fall.
// - interface select low is parallel, high serial, high with bus bit 15 byte mode.
// - byte mode sends each result as two bytes on the low eight lines.
// - oversampling ratio comes from a three-bit field, top pin most significant.
`timescale 1ns/1ps
module sac_conv_readout (
    input wire logic sys_clk, // core clock
    input wire logic reset_n, // synchronous system reset, active low
    input wire logic read_clk, // read strobe or serial clock from host
    input wire logic chip_select_n, // frames a readout, active low
    input wire logic start_group_a, // conversion start, lower channel group
    input wire logic start_group_b, // conversion start, upper channel group
    input wire logic reset_pin, // device reset pin, active high
    input wire logic range_sel, // input span select pin
    input wire logic interface_select, // parallel or serial/byte select
    input wire logic [2:0] oversample_ratio_sel, // oversampling ratio pins
    input wire logic [sac_pkg::CHANNELS*sac_pkg::RES_W-1:0] adc_result, // converter core results
    input wire logic [sac_pkg::RES_W-1:0] parallel_result_bus_i, // data pins, input side
    output logic [sac_pkg::RES_W-1:0] parallel_result_bus_o, // data pins, output side
    output logic [sac_pkg::RES_W-1:0] parallel_result_bus_oe, // data pins, drive enables
    output logic first_channel_flag_o, // first channel flag value
    output logic first_channel_flag_oe, // first channel flag drive enable
    output logic busy, // conversion in progress
    output logic hold_group_a, // lower group track-and-hold in hold
    output logic hold_group_b, // upper group track-and-hold in hold
    output logic range_wide // front end uses wide span
);
    localparam int SYNC_W = 10;

    logic [SYNC_W-1:0] pins_s;
    logic start_a_s;
    logic start_b_s;
    logic reset_pin_s;
    logic range_s;
    logic if_sel_s;
    logic byte_sel_s;
    logic high_byte_first_enable_s;
    logic [2:0] os_s;

    sac_sync2 #(.W(SYNC_W)) u_sync (
        .clk(sys_clk),
        .rst_n(reset_n),
        .d({start_group_a, start_group_b, reset_pin, range_sel, interface_select,
            parallel_result_bus_i[sac_pkg::DB_BYTE_SEL_BIT],
            parallel_result_bus_i[sac_pkg::DB_HIGH_BYTE_FIRST_ENABLE_BIT], oversample_ratio_sel}),
        .q(pins_s)
    );
    assign {start_a_s, start_b_s, reset_pin_s, range_s, if_sel_s, byte_sel_s, high_byte_first_enable_s, os_s} = pins_s;

    // edge detection on synchronised pins
    logic start_a_d_r;
    logic start_b_d_r;
    logic reset_pin_d_r;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            start_a_d_r <= 1'b0;
            start_b_d_r <= 1'b0;
            reset_pin_d_r <= 1'b0;
        end else begin
            start_a_d_r <= start_a_s;
            start_b_d_r <= start_b_s;
            reset_pin_d_r <= reset_pin_s;
        end
    end

    logic a_rise;
    logic b_rise;
    logic pin_reset;
    logic soft_rst;
    assign a_rise = start_a_s & ~start_a_d_r;
    assign b_rise = start_b_s & ~start_b_d_r;
    assign pin_reset = reset_pin_s & ~reset_pin_d_r;
    assign soft_rst = ~reset_n | pin_reset;

    // span select follows the pin
    logic range_wide_r;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            range_wide_r <= 1'b0;
        end else begin
            range_wide_r <= range_s;
        end
    end
    assign range_wide = range_wide_r;

    // interface mode, treated as a strap by the link side
    logic ser_mode_r;
    logic byte_mode_r;
    logic high_byte_first_enable_r;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ser_mode_r <= 1'b0;
            byte_mode_r <= 1'b0;
            high_byte_first_enable_r <= 1'b0;
        end else begin
            ser_mode_r <= if_sel_s & ~byte_sel_s;
            byte_mode_r <= if_sel_s & byte_sel_s;
            high_byte_first_enable_r <= high_byte_first_enable_s;
        end
    end

    // conversion sequencing
    sac_pkg::sac_conv_e state_r;
    sac_pkg::sac_conv_e state_nxt;
    logic hold_a_r;
    logic hold_b_r;
    logic [sac_pkg::CONV_CNT_W-1:0] conv_cnt_r;
    logic [sac_pkg::CONV_CNT_W-1:0] conv_len;
    logic [2:0] os_shift;
    logic conv_done;

    assign os_shift = (os_s > sac_pkg::OS_SEL_MAX) ? 3'h0 : os_s;
    assign conv_len = sac_pkg::CONV_CYC_V << os_shift;
    assign conv_done = (state_r == sac_pkg::SAC_CONV) && (conv_cnt_r == sac_pkg::CONV_LAST);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sac_pkg::SAC_IDLE: begin
                if (a_rise && b_rise) begin
                    state_nxt = sac_pkg::SAC_CONV;
                end else if (a_rise || b_rise) begin
                    state_nxt = sac_pkg::SAC_ARMED;
                end
            end
            sac_pkg::SAC_ARMED: begin
                if ((a_rise || hold_a_r) && (b_rise || hold_b_r)) begin
                    state_nxt = sac_pkg::SAC_CONV;
                end
            end
            sac_pkg::SAC_CONV: begin
                if (conv_done) begin
                    state_nxt = sac_pkg::SAC_IDLE;
                end
            end
            default: begin
                state_nxt = sac_pkg::SAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (soft_rst) begin
            state_r <= sac_pkg::SAC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // track-and-hold control per group; edges ignored while converting
    always_ff @(posedge sys_clk) begin
        if (soft_rst) begin
            hold_a_r <= 1'b0;
            hold_b_r <= 1'b0;
        end else if (conv_done) begin
            hold_a_r <= 1'b0;
            hold_b_r <= 1'b0;
        end else if (state_r != sac_pkg::SAC_CONV) begin
            if (a_rise) begin
                hold_a_r <= 1'b1;
            end
            if (b_rise) begin
                hold_b_r <= 1'b1;
            end
        end
    end
    assign hold_group_a = hold_a_r;
    assign hold_group_b = hold_b_r;

    always_ff @(posedge sys_clk) begin
        if (soft_rst) begin
            conv_cnt_r <= '0;
        end else if (state_r != sac_pkg::SAC_CONV && state_nxt == sac_pkg::SAC_CONV) begin
            conv_cnt_r <= conv_len;
        end else if (state_r == sac_pkg::SAC_CONV && !conv_done) begin
            conv_cnt_r <= conv_cnt_r - sac_pkg::CONV_LAST;
        end
    end
    assign busy = (state_r == sac_pkg::SAC_CONV);

    // output result registers, loaded as busy falls
    logic [sac_pkg::RES_W-1:0] result_r [sac_pkg::CHANNELS];
    genvar gi;
    generate
        for (gi = 0; gi < sac_pkg::CHANNELS; gi++) begin : g_res
            always_ff @(posedge sys_clk) begin
                if (soft_rst) begin
                    result_r[gi] <= sac_pkg::RES_ZERO;
                end else if (conv_done) begin
                    result_r[gi] <= adc_result[gi*sac_pkg::RES_W +: sac_pkg::RES_W];
                end
            end
        end
    endgenerate

    // link side: counters run on the host's strobe, cleared while deselected
    logic [sac_pkg::FALL_W-1:0] fall_cnt_r;
    logic [sac_pkg::BIT_W-1:0] bit_cnt_r;

    always_ff @(negedge read_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            fall_cnt_r <= '0;
        end else if (fall_cnt_r != sac_pkg::FALL_MAX) begin
            fall_cnt_r <= fall_cnt_r + sac_pkg::FALL_FIRST;
        end
    end

    always_ff @(posedge read_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            bit_cnt_r <= '0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 6'h01;
        end
    end

    // result selection for each interface
    logic [sac_pkg::FALL_W-1:0] read_idx;
    logic [sac_pkg::RES_W-1:0] par_word;
    logic [sac_pkg::RES_W-1:0] byte_word;
    logic [sac_pkg::BYTE_W-1:0] byte_out;
    logic [1:0] ser_ch;
    logic [3:0] ser_bit;
    logic serial_out_lower;
    logic serial_out_upper;
    logic [sac_pkg::RES_W-1:0] lower_word;
    logic [sac_pkg::RES_W-1:0] upper_word;

    assign read_idx = fall_cnt_r - sac_pkg::FALL_FIRST;
    assign par_word = result_r[read_idx[2:0]];
    assign byte_word = result_r[read_idx[3:1]];
    assign byte_out = (read_idx[0] ^ high_byte_first_enable_r) ? byte_word[sac_pkg::RES_W-1:sac_pkg::BYTE_W]
                                             : byte_word[sac_pkg::BYTE_W-1:0];
    assign ser_ch = bit_cnt_r[5:4];
    assign ser_bit = ~bit_cnt_r[3:0];
    assign lower_word = result_r[{1'b0, ser_ch}];
    assign upper_word = result_r[{1'b1, ser_ch}];
    assign serial_out_lower = lower_word[ser_bit];
    assign serial_out_upper = upper_word[ser_bit];

    logic read_active;
    assign read_active = ~chip_select_n & ~read_clk;

    always_comb begin
        parallel_result_bus_o = '0;
        parallel_result_bus_oe = '0;
        if (ser_mode_r) begin
            parallel_result_bus_o[sac_pkg::SER_LOWER_BIT] = serial_out_lower;
            parallel_result_bus_o[sac_pkg::SER_UPPER_BIT] = serial_out_upper;
            parallel_result_bus_oe[sac_pkg::SER_LOWER_BIT] = ~chip_select_n;
            parallel_result_bus_oe[sac_pkg::SER_UPPER_BIT] = ~chip_select_n;
        end else if (byte_mode_r) begin
            parallel_result_bus_o[sac_pkg::BYTE_W-1:0] = byte_out;
            parallel_result_bus_oe[sac_pkg::BYTE_W-1:0] = {sac_pkg::BYTE_W{read_active}};
        end else begin
            parallel_result_bus_o = par_word;
            parallel_result_bus_oe = {sac_pkg::RES_W{read_active}};
        end
    end

    assign first_channel_flag_oe = ~chip_select_n;
    assign first_channel_flag_o = ser_mode_r ? (fall_cnt_r < sac_pkg::SER_FLAG_FALLS)
                                             : (fall_cnt_r == sac_pkg::FALL_FIRST);

    // checks on the conversion and link sides
    sequence both_held_s;
        hold_a_r && hold_b_r && !busy;
    endsequence

    sequence conv_run_s;
        busy [*8];
    endsequence

    property busy_start_p;
        @(posedge sys_clk) disable iff (soft_rst)
        both_held_s |=> busy;
    endproperty

    property busy_min_p;
        @(posedge sys_clk) disable iff (soft_rst)
        $rose(busy) |-> conv_run_s;
    endproperty

    span_follow_a: assert property (@(posedge sys_clk) disable iff (!reset_n) ##1 range_wide == $past(range_s))
        else $error("span select does not follow the pin");
    hold_edge_a: assert property (@(posedge sys_clk) disable iff (soft_rst)
        a_rise && !busy && !conv_done |=> hold_group_a)
        else $error("group a not held after start edge");
    busy_start_a: assert property (busy_start_p)
        else $error("busy did not rise with both groups held");
    busy_hold_a: assert property (@(posedge sys_clk) disable iff (soft_rst)
        busy |-> hold_group_a && hold_group_b)
        else $error("busy without both groups held");
    busy_min_a: assert property (busy_min_p)
        else $error("conversion ended too early");
    edge_ignore_a: assert property (@(posedge sys_clk) disable iff (soft_rst)
        busy && !conv_done && (a_rise || b_rise) |=> busy && conv_cnt_r == $past(conv_cnt_r) - sac_pkg::CONV_LAST)
        else $error("start edge disturbed a running conversion");
    result_latch_a: assert property (@(posedge sys_clk) disable iff (soft_rst)
        $fell(busy) && !$past(soft_rst) |-> result_r[0] == $past(adc_result[sac_pkg::RES_W-1:0]))
        else $error("result not latched as busy fell");
    reset_abort_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pin_reset |=> !busy && !hold_group_a && result_r[0] == sac_pkg::RES_ZERO)
        else $error("reset pin did not abort and clear");
    bus_float_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !ser_mode_r && !byte_mode_r && chip_select_n |-> parallel_result_bus_oe == '0)
        else $error("parallel bus driven while deselected");
    flag_float_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        chip_select_n |-> !first_channel_flag_oe)
        else $error("flag driven while deselected");
    flag_serial_a: assert property (@(negedge read_clk) disable iff (chip_select_n)
        ser_mode_r && fall_cnt_r >= sac_pkg::SER_FLAG_FALLS |-> !first_channel_flag_o)
        else $error("serial flag still high after 16 falls");
endmodule

// [test/sac_host_model.sv]
// host side model: frames reads over the parallel, byte and serial links
`timescale 1ns/1ps
module sac_host_model (
    output logic read_clk, // read strobe or serial clock
    output logic chip_select_n, // frame select, active low
    input wire logic busy, // conversion running
    input wire logic [15:0] bus_o, // data pins, device side
    input wire logic [15:0] bus_oe, // data pin drive enables
    input wire logic flag_o, // first channel flag value
    input wire logic flag_oe, // first channel flag enable
    input wire logic [1:0] strap, // byte select and high byte first straps
    output logic [15:0] bus_i // resolved data pins
);
    localparam int HALF_NS = 24;
    logic [15:0] word_q [0:15];
    logic [15:0] oe_q [0:15];
    logic [15:0] rel_oe_q [0:15];
    logic [1:0] flag_q [0:64];
    logic [63:0] ser_lo_q;
    logic [63:0] ser_hi_q;
    logic [15:0] ser_oe_q;
    // released lines 13:0 show the inverse of the device value so stale data cannot pass; 15:14 carry the straps
    assign bus_i = (bus_oe & bus_o) | (~bus_oe & {strap, ~bus_o[13:0]});
    initial begin
        read_clk = 1'b1;
        chip_select_n = 1'b1;
    end
    task automatic par_frame(input int n);
        wait (busy === 1'b0);
        chip_select_n = 1'b0;
        #HALF_NS;
        for (int i = 0; i < n; i++) begin
            read_clk = 1'b0;
            #HALF_NS;
            word_q[i] = bus_o;
            oe_q[i] = bus_oe;
            flag_q[i] = {flag_oe, flag_o};
            read_clk = 1'b1;
            #HALF_NS;
            rel_oe_q[i] = bus_oe;
        end
        chip_select_n = 1'b1;
        #HALF_NS;
    endtask
    task automatic ser_frame();
        wait (busy === 1'b0);
        chip_select_n = 1'b0;
        #HALF_NS;
        ser_oe_q = bus_oe;
        flag_q[0] = {flag_oe, flag_o};
        ser_lo_q[63] = bus_o[7];
        ser_hi_q[63] = bus_o[8];
        for (int k = 1; k <= 64; k++) begin
            read_clk = 1'b0;
            #HALF_NS;
            flag_q[k] = {flag_oe, flag_o};
            read_clk = 1'b1;
            #HALF_NS;
            if (k < 64) begin
                ser_lo_q[63-k] = bus_o[7];
                ser_hi_q[63-k] = bus_o[8];
            end
        end
        chip_select_n = 1'b1;
        #HALF_NS;
    endtask
endmodule

// [test/simultaneous_adc_conversion_readout_tb.sv]
// self-checking bench for the conversion control and readout block
`timescale 1ns/1ps
module simultaneous_adc_conversion_readout_tb;
    typedef struct packed {logic range; logic [2:0] os; logic [15:0] cycles;} sac_row_s;
    localparam sac_row_s ROWS [0:7] = '{'{1'b1, 3'h0, 16'h0050}, '{1'b0, 3'h1, 16'h00A0},
        '{1'b1, 3'h2, 16'h0140}, '{1'b0, 3'h3, 16'h0280}, '{1'b1, 3'h4, 16'h0500},
        '{1'b0, 3'h5, 16'h0A00}, '{1'b1, 3'h6, 16'h1400}, '{1'b0, 3'h7, 16'h0050}};
    logic sys_clk, reset_n, read_clk, chip_select_n, start_group_a, start_group_b, reset_pin;
    logic range_sel, interface_select, flag_o, flag_oe, busy, hold_group_a, hold_group_b, range_wide;
    logic [2:0] oversample_ratio_sel;
    logic [sac_pkg::CHANNELS*sac_pkg::RES_W-1:0] adc_result;
    logic [15:0] bus_i, bus_o, bus_oe, w;
    logic [1:0] strap;
    int errors, samples_checked, n;
    sac_conv_readout i_sac_conv_readout (.sys_clk(sys_clk), .reset_n(reset_n), .read_clk(read_clk),
        .chip_select_n(chip_select_n), .start_group_a(start_group_a), .start_group_b(start_group_b),
        .reset_pin(reset_pin), .range_sel(range_sel), .interface_select(interface_select),
        .oversample_ratio_sel(oversample_ratio_sel), .adc_result(adc_result), .parallel_result_bus_i(bus_i),
        .parallel_result_bus_o(bus_o), .parallel_result_bus_oe(bus_oe), .first_channel_flag_o(flag_o),
        .first_channel_flag_oe(flag_oe), .busy(busy), .hold_group_a(hold_group_a),
        .hold_group_b(hold_group_b), .range_wide(range_wide));
    sac_host_model i_sac_host_model (.read_clk(read_clk), .chip_select_n(chip_select_n), .busy(busy),
        .bus_o(bus_o), .bus_oe(bus_oe), .flag_o(flag_o), .flag_oe(flag_oe), .strap(strap), .bus_i(bus_i));
    function automatic logic [15:0] exp_res(input int k);
        return {4'hC, 4'(k), 8'h5A ^ 8'(k)};
    endfunction
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkbit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic load(input logic [15:0] m);
        @(posedge sys_clk);
        for (int k = 0; k < 8; k++) begin
            adc_result[16*k +: 16] <= exp_res(k) ^ m;
        end
    endtask
    task automatic pulse(input logic a, input logic b);
        @(posedge sys_clk);
        start_group_a <= a;
        start_group_b <= b;
        repeat (4) @(posedge sys_clk);
        start_group_a <= 1'b0;
        start_group_b <= 1'b0;
    endtask
    task automatic busy_len(output int cnt);
        cnt = 0;
        for (int t = 0; t < 20 && busy !== 1'b1; t++) begin
            @(posedge sys_clk);
        end
        chk16({hold_group_a, hold_group_b, 14'h0}, 16'hC000);
        while (busy === 1'b1 && cnt < 6000) begin
            @(posedge sys_clk);
            cnt++;
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // longest path is about 10600 cycles of conversions and reads
    initial begin
        #(40000 * 50);
        errors++;
        complete_run();
    end
    initial begin
        errors = 0;
        samples_checked = 0;
        {reset_n, start_group_a, start_group_b, reset_pin, range_sel, interface_select} = 6'h00;
        oversample_ratio_sel = 3'h0;
        strap = 2'b00;
        adc_result = '0;
        repeat (8) @(posedge sys_clk);
        chkbit(busy, 1'b0);
        reset_n <= 1'b1;
        load(16'h0000);
        reset_pin <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset_pin <= 1'b0;
        repeat (8) @(posedge sys_clk);
        $display("test reset done");
        foreach (ROWS[r]) begin
            range_sel <= ROWS[r].range;
            oversample_ratio_sel <= ROWS[r].os;
            repeat (4) @(posedge sys_clk);
            chkbit(range_wide, ROWS[r].range);
            pulse(1'b1, 1'b1);
            busy_len(n);
            chk16(16'(n), ROWS[r].cycles);
            chk16({hold_group_a, hold_group_b, 14'h0}, 16'h0000);
        end
        $display("test conversion rows done");
        oversample_ratio_sel <= 3'h0;
        i_sac_host_model.par_frame(9);
        for (int i = 0; i < 9; i++) begin
            chk16(i_sac_host_model.word_q[i], exp_res(i % 8));
            chk16(i_sac_host_model.oe_q[i], 16'hFFFF);
            chk16(i_sac_host_model.rel_oe_q[i], 16'h0000);
            chk16({14'h0, i_sac_host_model.flag_q[i]}, {14'h0, 1'b1, (i == 0)});
        end
        chkbit(flag_oe, 1'b0);
        $display("test parallel done");
        for (int hb = 1; hb >= 0; hb--) begin
            @(posedge sys_clk);
            interface_select <= 1'b1;
            strap <= {1'b1, hb[0]};
            repeat (4) @(posedge sys_clk);
            i_sac_host_model.par_frame(4);
            for (int i = 0; i < 4; i++) begin
                w = exp_res(i / 2);
                chk16({8'h00, i_sac_host_model.word_q[i][7:0]}, {8'h00, ((i % 2 == 0) == (hb == 1)) ? w[15:8] : w[7:0]});
                chk16(i_sac_host_model.oe_q[i], 16'h00FF);
                chk16({14'h0, i_sac_host_model.flag_q[i]}, {14'h0, 1'b1, (i == 0)});
            end
        end
        $display("test byte done");
        @(posedge sys_clk);
        strap <= 2'b00;
        repeat (4) @(posedge sys_clk);
        i_sac_host_model.ser_frame();
        chk16(i_sac_host_model.ser_oe_q & 16'h0180, 16'h0180);
        for (int c = 0; c < 4; c++) begin
            chk16(i_sac_host_model.ser_lo_q[63-16*c -: 16], exp_res(c));
            chk16(i_sac_host_model.ser_hi_q[63-16*c -: 16], exp_res(c + 4));
        end
        for (int k = 0; k <= 16; k++) begin
            chk16({14'h0, i_sac_host_model.flag_q[k]}, {14'h0, 1'b1, (k < 16)});
        end
        $display("test serial done");
        @(posedge sys_clk);
        interface_select <= 1'b0;
        pulse(1'b1, 1'b0);
        repeat (10) @(posedge sys_clk);
        chkbit(busy, 1'b0);
        chk16({hold_group_a, hold_group_b, 14'h0}, 16'h8000);
        pulse(1'b0, 1'b1);
        chkbit(busy, 1'b1);
        load(16'hFFFF);
        repeat (19) @(posedge sys_clk);
        pulse(1'b1, 1'b1);
        busy_len(n);
        chk16(16'(n), 16'h0037);
        repeat (10) @(posedge sys_clk);
        chkbit(busy, 1'b0);
        i_sac_host_model.par_frame(1);
        chk16(i_sac_host_model.word_q[0], ~exp_res(0));
        $display("test start order done");
        pulse(1'b1, 1'b1);
        repeat (20) @(posedge sys_clk);
        reset_pin <= 1'b1;
        repeat (3) @(posedge sys_clk);
        reset_pin <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chkbit(busy, 1'b0);
        chk16({hold_group_a, hold_group_b, 14'h0}, 16'h0000);
        i_sac_host_model.par_frame(8);
        for (int i = 0; i < 8; i++) begin
            chk16(i_sac_host_model.word_q[i], 16'h0000);
        end
        $display("test reset pin done");
        complete_run();
    end
endmodule
